/* File: hw/position_and_operation_data_manager.sv */
// Command position, origin tracking, wrap, soft limits, parameter store and operation table.
// Assumes motion inputs on core_clk; start, preset and select pins arrive asynchronously.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Home completion or preset input marks the origin defined.
// - Reset, current removal or a configure command marks the origin undefined.
// - With alarm enabled and no origin, start, sequential or select inputs raise the alarm.
// - Missing-origin alarm enable is one bit, 1 enables, resets to 0.
// - Wrapping returns the command position to 0 past the range.
// - Wrapped position stays from 0 to range minus one; a preset input loads the preset word without this range check.
// - Wrap enable is one bit, 1 enables, resets disabled.
// - Wrap range holds 1 to 8388607 steps, resets to 500.
// - Wrapping suppresses software limit checking.
// - After reset, stored nonvolatile words are copied to working RAM and applied.
// - Working RAM is cleared by power loss; the nonvolatile copy survives it.
// - Settings apply at once, after motion stops, after configure, or at power-up.
// - Register writes change working RAM only; saving needs an explicit command.
// - Sixty-four operation entries, indices 0 to 63, each with its own fields.
// - Entry position is a signed 24-bit step count, resets to 0.
// - Entry speed spans 0 to 1000000 Hz, resets to 1000.
// - Entry mode bit: 0 relative, 1 absolute, resets relative.
// - Entry chaining 0, 1 or 2, resets 0, applies only after motion stops.
// - Entry acceleration and deceleration span 1 to 1000000, reset to 30000.
// - Common ramp setting replaces entry ramps with shared values; separate after reset.
// - Entry sequential flag: 1 enables, resets disabled.
// - Entry dwell spans 0 to 50000, resets to 0.
// - Positive and negative soft limits stop motion when checking is active.
module position_and_operation_data_manager
  import posmgr_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // Motion sequencer
  input  wire logic             step_pulse,
  input  wire logic             step_up,
  input  wire logic             home_done,
  input  wire logic             motion_active,
  input  wire logic             current_off,
  input  wire logic [IDX_W-1:0] ent_idx,
  output op_entry_s             ent_out,
  output logic      [POS_W-1:0] cmd_pos,
  output logic                  ot_stop,
  // Control pins
  input  wire logic             preset_input,
  input  wire logic             start_input,
  input  wire logic             sequential_start_input,
  input  wire logic [5:0]       direct_select_inputs,
  // Status
  output logic                  origin_set,
  output logic                  origin_alarm,
  output logic                  start_block,
  output logic                  start_grant,
  output logic                  init_busy
);
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] clampu(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    if (v < lo)
      return lo;
    if (v > hi)
      return hi;
    return v;
  endfunction

  function automatic logic [31:0] sx24(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  function automatic logic [31:0] glob_rst(input logic [2:0] i);
    case (i)
      G_CTRL:         return CTRL_RST;
      G_WRAP:         return WRAP_RST;
      G_PLIM:         return PLIM_RST;
      G_NLIM:         return NLIM_RST;
      G_CACC, G_CDEC: return RAMP_RST;
      default:        return ZERO;
    endcase
  endfunction

  // ==========================================================================
  // Declarations
  logic [31:0]              glob_ff [GLOB_N];
  logic [31:0]              boot_glob [GLOB_N];
  logic [31:0]              nv_ff [GLOB_N];
  logic [GLOB_N-1:0]        nv_ok_ff = '0;
  logic [POS_W-1:0]         t_pos [ENTRIES];
  logic [SPD_W-1:0]         t_spd [ENTRIES];
  logic                     t_abs [ENTRIES];
  chain_e                   t_chain [ENTRIES];
  logic [RAMP_W-1:0]        t_acc [ENTRIES];
  logic [RAMP_W-1:0]        t_dec [ENTRIES];
  logic                     t_seq [ENTRIES];
  logic [DWELL_W-1:0]       t_dwell [ENTRIES];
  boot_e                    boot_ff;
  logic [IDX_W-1:0]         clr_idx_ff;
  logic [IDX_W-1:0]         tidx_ff;
  logic [8:0]               s1_ff, s2_ff, s3_ff, filt_ff;
  logic [8:0]               rise;
  logic                     run, cmd_wr, cfg_cmd, save_cmd, clr_cmd, start_evt, preset_evt;
  logic                     glob_hit;
  logic [2:0]               gidx;
  logic [31:0]              glob_w, spd_c, acc_c, dec_c, dwl_c;
  logic                     wrap_eff_ff, unit_eff_ff, origin_ff, alarm_ff, ot_stop_ff;
  logic signed [POS_W-1:0]  rng_eff_ff, pos_ff, plim, nlim;
  logic                     alm_en, sot_active, limit_hit, need_home;
  logic [31:0]              rdata_ff;
  op_entry_s                ent_ff;

  assign run       = (boot_ff == BT_RUN);
  assign init_busy = !run;
  assign glob_hit  = (reg_addr < OFF_CMD);
  assign gidx      = reg_addr[4:2];
  assign cmd_wr    = reg_wr && run && (reg_addr == OFF_CMD);
  assign cfg_cmd   = cmd_wr && reg_wdata[CMD_CONFIG];
  assign save_cmd  = cmd_wr && reg_wdata[CMD_SAVE];
  assign clr_cmd   = cmd_wr && reg_wdata[CMD_ALM_CLR];
  assign alm_en    = glob_ff[G_CTRL][CTRL_ALM_EN];
  assign plim      = glob_ff[G_PLIM][POS_W-1:0];
  assign nlim      = glob_ff[G_NLIM][POS_W-1:0];
  assign spd_c     = clampu(reg_wdata, ZERO, SPD_MAX);
  assign acc_c     = clampu(reg_wdata, ONE, RAMP_MAX);
  assign dec_c     = acc_c;
  assign dwl_c     = clampu(reg_wdata, ZERO, DWELL_MAX);

  // Range-checked value of a global write
  always_comb begin
    case (gidx)
      G_CTRL:         glob_w = reg_wdata & CTRL_MASK;
      G_WRAP:         glob_w = clampu(reg_wdata, ONE, WRAP_MAX);
      G_CACC, G_CDEC: glob_w = clampu(reg_wdata, ONE, RAMP_MAX);
      default:        glob_w = sx24(reg_wdata[23:0]);
    endcase
  end

  // ==========================================================================
  // Power-up sequence: clear the table, then pull in the saved words
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      boot_ff    <= BT_CLEAR;
      clr_idx_ff <= '0;
    end else begin
      case (boot_ff)
        BT_CLEAR: begin
          clr_idx_ff <= clr_idx_ff + 1'b1;
          if (clr_idx_ff == IDX_W'(ENTRIES - 1))
            boot_ff <= BT_LOAD;
        end
        BT_LOAD: boot_ff <= BT_RUN;
        BT_RUN:  boot_ff <= BT_RUN;
        default: boot_ff <= BT_CLEAR;
      endcase
    end
  end

  // Value each global word takes when the boot copy happens
  always_comb begin
    for (int i = 0; i < GLOB_N; i++)
      boot_glob[i] = nv_ok_ff[i] ? nv_ff[i] : glob_ff[i];
  end

  // Working RAM for global settings; lost on reset, refilled from the saved copy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < GLOB_N; i++)
        glob_ff[i] <= glob_rst(3'(i));
    end else if (boot_ff == BT_LOAD) begin
      for (int i = 0; i < GLOB_N; i++)
        glob_ff[i] <= boot_glob[i];
    end else if (reg_wr && run && glob_hit) begin
      glob_ff[gidx] <= glob_w;
    end
  end

  // Nonvolatile copy: never touched by reset, written only by the save command
  always_ff @(posedge core_clk) begin
    if (save_cmd) begin
      for (int i = 0; i < GLOB_N; i++)
        nv_ff[i] <= glob_ff[i];
      nv_ok_ff <= '1;
    end
  end

  // Settings that take effect at configure (wrap) or only at power-up (ramp unit)
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrap_eff_ff <= 1'b0;
      rng_eff_ff  <= POS_W'(WRAP_RST);
      unit_eff_ff <= 1'b0;
    end else if (boot_ff == BT_LOAD) begin
      wrap_eff_ff <= boot_glob[G_CTRL][CTRL_WRAP_EN];
      rng_eff_ff  <= boot_glob[G_WRAP][POS_W-1:0];
      unit_eff_ff <= boot_glob[G_CTRL][CTRL_UNIT_T];
    end else if (cfg_cmd) begin
      wrap_eff_ff <= glob_ff[G_CTRL][CTRL_WRAP_EN];
      rng_eff_ff  <= glob_ff[G_WRAP][POS_W-1:0];
    end
  end

  // ==========================================================================
  // Operation table
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      tidx_ff <= '0;
    else if (reg_wr && run && reg_addr == OFF_TIDX)
      tidx_ff <= reg_wdata[IDX_W-1:0];
  end

  // Defaults during power-up clear, then field writes at the selected entry
  always_ff @(posedge core_clk) begin
    if (boot_ff == BT_CLEAR) begin
      t_pos[clr_idx_ff]   <= '0;
      t_spd[clr_idx_ff]   <= SPD_RST[SPD_W-1:0];
      t_abs[clr_idx_ff]   <= 1'b0;
      t_chain[clr_idx_ff] <= CH_SINGLE;
      t_acc[clr_idx_ff]   <= RAMP_RST[RAMP_W-1:0];
      t_dec[clr_idx_ff]   <= RAMP_RST[RAMP_W-1:0];
      t_seq[clr_idx_ff]   <= 1'b0;
      t_dwell[clr_idx_ff] <= '0;
    end else if (reg_wr && run) begin
      case (reg_addr)
        OFF_TPOS:   t_pos[tidx_ff] <= reg_wdata[POS_W-1:0];
        OFF_TSPD:   t_spd[tidx_ff] <= spd_c[SPD_W-1:0];
        OFF_TFLAG: begin
          t_abs[tidx_ff]   <= reg_wdata[FL_ABS];
          t_chain[tidx_ff] <= (reg_wdata[FL_CH_LO +: 2] == 2'b11) ? CH_SINGLE
                                                                  : chain_e'(reg_wdata[FL_CH_LO +: 2]);
          t_seq[tidx_ff]   <= reg_wdata[FL_SEQ];
        end
        OFF_TACC:   t_acc[tidx_ff] <= acc_c[RAMP_W-1:0];
        OFF_TDEC:   t_dec[tidx_ff] <= dec_c[RAMP_W-1:0];
        OFF_TDWELL: t_dwell[tidx_ff] <= dwl_c[DWELL_W-1:0];
        default: ;
      endcase
    end
  end

  // Entry handed to the sequencer; chaining frozen while a motion runs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ent_ff <= '0;
    end else begin
      ent_ff.pos      <= t_pos[ent_idx];
      ent_ff.speed    <= t_spd[ent_idx];
      ent_ff.absolute <= t_abs[ent_idx];
      ent_ff.chain    <= motion_active ? ent_ff.chain : t_chain[ent_idx];
      ent_ff.accel    <= glob_ff[G_CTRL][CTRL_RAMP_COM] ? glob_ff[G_CACC][RAMP_W-1:0]
                                                        : t_acc[ent_idx];
      ent_ff.decel    <= glob_ff[G_CTRL][CTRL_RAMP_COM] ? glob_ff[G_CDEC][RAMP_W-1:0]
                                                        : t_dec[ent_idx];
      ent_ff.seq      <= t_seq[ent_idx];
      ent_ff.dwell    <= t_dwell[ent_idx];
    end
  end
  assign ent_out = ent_ff;

  // ==========================================================================
  // Pin synchronisers: a change counts once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      filt_ff <= '0;
    end else begin
      s1_ff   <= {preset_input, start_input, sequential_start_input, direct_select_inputs};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      for (int i = 0; i < 9; i++)
        if (s2_ff[i] == s3_ff[i])
          filt_ff[i] <= s3_ff[i];
    end
  end
  assign rise       = s2_ff & s3_ff & ~filt_ff;
  assign preset_evt = rise[8];
  assign start_evt  = |rise[7:0];

  // ==========================================================================
  // Origin and missing-origin alarm
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      origin_ff <= 1'b0;
    else if (home_done || preset_evt)
      origin_ff <= 1'b1;
    else if (current_off || cfg_cmd)
      origin_ff <= 1'b0;
  end

  assign need_home   = alm_en && !origin_ff;
  assign start_block = need_home;
  assign start_grant = start_evt && !need_home;

  // Alarm is sticky; a new start event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      alarm_ff <= 1'b0;
    else if (start_evt && need_home)
      alarm_ff <= 1'b1;
    else if (clr_cmd)
      alarm_ff <= 1'b0;
  end

  // ==========================================================================
  // Command position counter with wrap
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pos_ff <= '0;
    end else if (home_done) begin
      pos_ff <= '0;
    end else if (preset_evt) begin
      pos_ff <= glob_ff[G_PRESET][POS_W-1:0];
    end else if (cfg_cmd) begin
      if (glob_ff[G_CTRL][CTRL_WRAP_EN] &&
          (pos_ff < 0 || pos_ff >= $signed(glob_ff[G_WRAP][POS_W-1:0])))
        pos_ff <= '0;
    end else if (step_pulse) begin
      if (wrap_eff_ff && step_up && pos_ff >= rng_eff_ff - 1)
        pos_ff <= '0;
      else if (wrap_eff_ff && !step_up && pos_ff <= 0)
        pos_ff <= POS_W'(rng_eff_ff - 1);
      else
        pos_ff <= step_up ? POS_W'(pos_ff + 1) : POS_W'(pos_ff - 1);
    end
  end
  assign cmd_pos = pos_ff;

  // Soft limits: active after origin is set, never while wrapping
  assign sot_active = glob_ff[G_CTRL][CTRL_SOT_EN] && !wrap_eff_ff && origin_ff;
  assign limit_hit  = sot_active && (step_up ? pos_ff >= plim : pos_ff <= nlim);

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ot_stop_ff <= 1'b0;
    else
      ot_stop_ff <= limit_hit && motion_active;
  end
  assign ot_stop      = ot_stop_ff;
  assign origin_set   = origin_ff;
  assign origin_alarm = alarm_ff;

  // ==========================================================================
  // Register read port: data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst || !reg_rd) begin
      rdata_ff <= '0;
    end else if (glob_hit) begin
      rdata_ff <= glob_ff[gidx];
    end else begin
      case (reg_addr)
        OFF_STATUS: rdata_ff <= {25'h0, limit_hit, unit_eff_ff, sot_active, wrap_eff_ff,
                                 init_busy, alarm_ff, origin_ff};
        OFF_POS:    rdata_ff <= sx24(pos_ff);
        OFF_TIDX:   rdata_ff <= {26'h0, tidx_ff};
        OFF_TPOS:   rdata_ff <= sx24(t_pos[tidx_ff]);
        OFF_TSPD:   rdata_ff <= {12'h0, t_spd[tidx_ff]};
        OFF_TFLAG:  rdata_ff <= {28'h0, t_seq[tidx_ff], t_chain[tidx_ff], t_abs[tidx_ff]};
        OFF_TACC:   rdata_ff <= {12'h0, t_acc[tidx_ff]};
        OFF_TDEC:   rdata_ff <= {12'h0, t_dec[tidx_ff]};
        OFF_TDWELL: rdata_ff <= {16'h0, t_dwell[tidx_ff]};
        default:    rdata_ff <= '0;
      endcase
    end
  end
  assign reg_rdata = rdata_ff;

  // ==========================================================================
  // Checks
  origin_home_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    home_done |=> origin_set ##1 (origin_set || $past(current_off) || $past(cfg_cmd)))
    else $error("origin not set by home");
  origin_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (current_off && !home_done && !preset_evt) |=> !origin_set) else $error("origin kept after current off");
  alarm_raise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (start_evt && alm_en && !origin_ff) |-> start_block ##1 origin_alarm) else $error("missing-origin alarm not raised");
  alarm_rst_a: assert property (@(posedge core_clk)
    sys_rst |=> !alm_en && !wrap_eff_ff && !origin_alarm) else $error("alarm or wrap enable not reset");
  wrap_roll_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (step_pulse && step_up && wrap_eff_ff && pos_ff == rng_eff_ff - 1 && !home_done && !preset_evt && !cfg_cmd)
    |=> cmd_pos == '0) else $error("wrap did not return to zero");
  wrap_bounds_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrap_eff_ff && !$past(preset_evt) |-> (pos_ff >= 0 && pos_ff < rng_eff_ff)) else $error("position outside wrap range");
  range_clamp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    glob_ff[G_WRAP] >= ONE && glob_ff[G_WRAP] <= WRAP_MAX) else $error("wrap range out of bounds");
  wrap_sot_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrap_eff_ff && $past(wrap_eff_ff) |-> !ot_stop && !sot_active) else $error("soft limit active while wrapping");
  chain_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (motion_active && $past(motion_active)) |-> $stable(ent_out.chain)) else $error("chaining changed during motion");
  ramp_common_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (glob_ff[G_CTRL][CTRL_RAMP_COM] && $stable(glob_ff[G_CACC])) |=> ent_out.accel == $past(glob_ff[G_CACC][RAMP_W-1:0]))
    else $error("common acceleration not used");
  soft_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (motion_active && sot_active && step_up && pos_ff >= plim) |=> ot_stop) else $error("positive soft limit ignored");
endmodule // position_and_operation_data_manager
`default_nettype wire

/* File: shared/posmgr_pkg.sv */
// Constants, types and register map of the position and operation data manager.
// Assumes a 32-bit register port with byte addresses and one core clock.
package posmgr_pkg;
  // ==========================================================================
  // Widths and sizes
  localparam int POS_W   = 24;
  localparam int SPD_W   = 20;
  localparam int RAMP_W  = 20;
  localparam int DWELL_W = 16;
  localparam int ENTRIES = 64;
  localparam int IDX_W   = 6;
  localparam int GLOB_N  = 7;
  // ==========================================================================
  // Register byte offsets; global words sit at index times four
  localparam logic [2:0] G_CTRL   = 3'h0;
  localparam logic [2:0] G_WRAP   = 3'h1;
  localparam logic [2:0] G_PLIM   = 3'h2;
  localparam logic [2:0] G_NLIM   = 3'h3;
  localparam logic [2:0] G_CACC   = 3'h4;
  localparam logic [2:0] G_CDEC   = 3'h5;
  localparam logic [2:0] G_PRESET = 3'h6;
  localparam logic [7:0] OFF_CMD    = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_POS    = 8'h24;
  localparam logic [7:0] OFF_TIDX   = 8'h28;
  localparam logic [7:0] OFF_TPOS   = 8'h2C;
  localparam logic [7:0] OFF_TSPD   = 8'h30;
  localparam logic [7:0] OFF_TFLAG  = 8'h34;
  localparam logic [7:0] OFF_TACC   = 8'h38;
  localparam logic [7:0] OFF_TDEC   = 8'h3C;
  localparam logic [7:0] OFF_TDWELL = 8'h40;
  // ==========================================================================
  // Field positions
  localparam int CTRL_ALM_EN   = 0;
  localparam int CTRL_WRAP_EN  = 1;
  localparam int CTRL_SOT_EN   = 2;
  localparam int CTRL_RAMP_COM = 3;
  localparam int CTRL_UNIT_T   = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_001F;
  localparam int CMD_CONFIG  = 0;
  localparam int CMD_SAVE    = 1;
  localparam int CMD_ALM_CLR = 2;
  localparam int FL_ABS   = 0;
  localparam int FL_CH_LO = 1;
  localparam int FL_SEQ   = 3;
  localparam int ST_ORIGIN = 0;
  localparam int ST_ALARM  = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_WRAP   = 3;
  localparam int ST_SOT    = 4;
  localparam int ST_UNIT   = 5;
  localparam int ST_LIMIT  = 6;
  // ==========================================================================
  // Reset values and ranges
  localparam logic [31:0] CTRL_RST   = 32'h0000_0004;
  localparam logic [31:0] WRAP_RST   = 32'h0000_01F4;
  localparam logic [31:0] PLIM_RST   = 32'h007F_FFFF;
  localparam logic [31:0] NLIM_RST   = 32'hFF80_0000;
  localparam logic [31:0] RAMP_RST   = 32'h0000_7530;
  localparam logic [31:0] SPD_RST    = 32'h0000_03E8;
  localparam logic [31:0] WRAP_MAX   = 32'h007F_FFFF;
  localparam logic [31:0] SPD_MAX    = 32'h000F_4240;
  localparam logic [31:0] RAMP_MAX   = 32'h000F_4240;
  localparam logic [31:0] DWELL_MAX  = 32'h0000_C350;
  localparam logic [31:0] ONE        = 32'h0000_0001;
  localparam logic [31:0] ZERO       = 32'h0000_0000;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {CH_SINGLE = 2'b00, CH_LINKED = 2'b01, CH_DWELL = 2'b10} chain_e;
  typedef enum logic [1:0] {BT_CLEAR = 2'b00, BT_LOAD = 2'b01, BT_RUN = 2'b10} boot_e;
  typedef struct packed {
    logic [POS_W-1:0]   pos;
    logic [SPD_W-1:0]   speed;
    logic               absolute;
    chain_e             chain;
    logic [RAMP_W-1:0]  accel;
    logic [RAMP_W-1:0]  decel;
    logic               seq;
    logic [DWELL_W-1:0] dwell;
  } op_entry_s;
endpackage

/* File: sim/pin_host_model.sv */
// Host-side model that drives the preset, start and select pins.
// Assumes requests on core_clk; each pin pulse is held four cycles, then released.
`timescale 1ns/100ps
`default_nettype none
module pin_host_model (
  // Clock, reset and request
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       pulse_req,
  input  wire logic [3:0] pin_sel,
  // Pins
  output logic            preset_input,
  output logic            start_input,
  output logic            sequential_start_input,
  output logic [5:0]      direct_select_inputs
);
  logic [8:0] pins_ff;
  logic [2:0] hold_ff;
  // ====
  // Pulse one pin long enough for the input filter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pins_ff <= 9'h000;
      hold_ff <= 3'h0;
    end else if (pulse_req) begin
      pins_ff <= 9'h001 << pin_sel;
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
      if (hold_ff == 3'h1) pins_ff <= 9'h000;
    end
  end
  assign {preset_input, direct_select_inputs, sequential_start_input, start_input} = pins_ff;
endmodule // pin_host_model
`default_nettype wire

/* File: sim/position_and_operation_data_manager_bench.sv */
// Self-checking bench of the position and operation data manager.
// Assumes the pin host model and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module position_and_operation_data_manager_bench;
  import posmgr_pkg::*;
  logic core_clk, sys_rst, reg_wr, reg_rd, step_pulse, step_up, home_done, motion_active;
  logic current_off, preset_input, start_input, sequential_start_input, pulse_req;
  logic origin_set, origin_alarm, start_block, start_grant, init_busy, ot_stop, grant_seen;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v, seed, rng, pv;
  logic [5:0] ent_idx, direct_select_inputs;
  logic [3:0] pin_sel;
  logic [23:0] cmd_pos;
  op_entry_s ent_out;
  int error_cnt, tests_run, n;
  position_and_operation_data_manager DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .step_pulse, .step_up, .home_done, .motion_active, .current_off, .ent_idx,
    .ent_out, .cmd_pos, .ot_stop, .preset_input, .start_input, .sequential_start_input,
    .direct_select_inputs, .origin_set, .origin_alarm, .start_block, .start_grant, .init_busy);
  pin_host_model host (.core_clk, .sys_rst, .pulse_req, .pin_sel, .preset_input, .start_input,
    .sequential_start_input, .direct_select_inputs);
  // Remembers any start grant since the last reset
  always @(posedge core_clk) grant_seen <= sys_rst ? 1'b0 : (grant_seen | start_grant);
  // ====
  // Clock, expectation helpers and bus tasks
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] sx(logic [31:0] v);
    return {{8{v[23]}}, v[23:0]};
  endfunction
  task automatic conclude;
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int k); repeat (k) @(posedge core_clk); endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk); reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic pin(logic [3:0] s);
    @(posedge core_clk); pin_sel <= s; pulse_req <= 1'b1;
    @(posedge core_clk); pulse_req <= 1'b0;
    cyc(8); #1;
  endtask
  task automatic boot;
    sys_rst <= 1'b1;
    cyc(6); sys_rst <= 1'b0;
    for (int i = 0; i < 100 && init_busy !== 1'b0; i++) cyc(1);
    if (init_busy !== 1'b0) begin error_cnt++; conclude; end
  endtask
  // ====
  // Main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, step_pulse, step_up, home_done, motion_active, current_off} = 8'h80;
    {reg_addr, reg_wdata, ent_idx, pin_sel, pulse_req} = 51'h0;
    error_cnt = 0; tests_run = 0; seed = 32'h5DACCB34;
    boot;
    rd(8'h00); chk("ctrl", CTRL_RST, rd_v);
    rd(8'h04); chk("wrap", WRAP_RST, rd_v);
    rd(8'h08); chk("plim", PLIM_RST, rd_v);
    wr(OFF_TIDX, 32'h3F); rd(OFF_TSPD); chk("tspd", SPD_RST, rd_v);
    rd(OFF_TACC); chk("tacc", RAMP_RST, rd_v);
    rd(OFF_TFLAG); chk("tflag", ZERO, rd_v);
    rd(OFF_TDWELL); chk("tdwell", ZERO, rd_v);
    // Every start-type pin raises the alarm while no origin
    wr(8'h00, 32'h5);
    for (int k = 0; k < 8; k++) begin
      wr(OFF_CMD, 32'h4); #1 chk("almclr", ZERO, {31'h0, origin_alarm});
      pin(4'(k)); chk("alarm", ONE, {31'h0, origin_alarm});
    end
    chk("grant0", ZERO, {31'h0, grant_seen}); chk("block", ONE, {31'h0, start_block});
    pin(4'h8); chk("preset", ONE, {31'h0, origin_set});
    wr(OFF_CMD, 32'h4); pin(4'h0); chk("grant", ONE, {31'h0, grant_seen});
    chk("noalarm", ZERO, {30'h0, origin_alarm, start_block});
    // Soft limit stop and chaining frozen while a motion runs
    wr(8'h08, ZERO); wr(OFF_TIDX, ZERO);
    @(posedge core_clk); motion_active <= 1'b1; step_up <= 1'b1;
    cyc(2); #1 chk("otstop", ONE, {31'h0, ot_stop});
    wr(OFF_TFLAG, 32'hD); cyc(2);
    #1 chk("chainrun", 32'h9, {28'h0, ent_out.seq, ent_out.chain, ent_out.absolute});
    @(posedge core_clk); motion_active <= 1'b0;
    cyc(3); #1 chk("chainstop", 32'hD, {28'h0, ent_out.seq, ent_out.chain, ent_out.absolute});
    chk("otidle", ZERO, {31'h0, ot_stop});
    @(posedge core_clk); current_off <= 1'b1;
    @(posedge core_clk); current_off <= 1'b0;
    cyc(1); #1 chk("curoff", ZERO, {31'h0, origin_set});
    // Random wrap range and random step count
    seed = xs(seed); rng = {28'h0, seed[3:0]} + 32'h2; n = int'(seed[12:5]);
    wr(8'h04, rng); wr(8'h00, 32'h7); pin(4'h8); wr(OFF_CMD, ONE);
    cyc(1); #1 chk("config", ZERO, {31'h0, origin_set});
    @(posedge core_clk); home_done <= 1'b1; step_up <= 1'b1;
    @(posedge core_clk); home_done <= 1'b0; step_pulse <= (n != 0);
    repeat (n) @(posedge core_clk);
    step_pulse <= 1'b0;
    cyc(1); #1 chk("cmdpos", 32'(n) % rng, {8'h0, cmd_pos});
    @(posedge core_clk); motion_active <= 1'b1;
    cyc(2); #1 chk("wrapsot", ZERO, {31'h0, ot_stop});
    @(posedge core_clk); motion_active <= 1'b0;
    rd(OFF_STATUS); chk("status", 32'h9, rd_v & 32'h19);
    // Table entries keep their own fields, speed clamps
    seed = xs(seed); pv = seed;
    wr(OFF_TIDX, 32'h3F); wr(OFF_TPOS, pv); rd(OFF_TPOS); chk("tpos", sx(pv), rd_v);
    wr(OFF_TSPD, 32'h00FFFFFF); rd(OFF_TSPD); chk("tspdmax", SPD_MAX, rd_v);
    @(posedge core_clk); ent_idx <= 6'h3F; cyc(2); #1 chk("entpos", {8'h0, pv[23:0]}, {8'h0, ent_out.pos});
    wr(OFF_TIDX, ZERO); rd(OFF_TPOS); chk("tpos0", ZERO, rd_v);
    wr(8'h10, 32'h1234); wr(8'h00, 32'hF); cyc(2); #1 chk("comacc", 32'h1234, {12'h0, ent_out.accel});
    // Save, change RAM only, power cycle
    wr(OFF_CMD, 32'h2); cyc(2); wr(8'h04, 32'h4D);
    boot;
    rd(8'h04); chk("nvwrap", rng, rd_v);
    wr(OFF_TIDX, 32'h3F); rd(OFF_TPOS); chk("ramlost", ZERO, rd_v);
    conclude;
  end
endmodule // position_and_operation_data_manager_bench
`default_nettype wire
